// ==== pmcs_pkg.sv ====
// Constants of the power and controller status register slice.
// Assumes a byte-wide register port driven by the serial host front end.
package pmcs_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_RATE_HI  = 8'h76;
  localparam logic [7:0] ADDR_RATE_LO  = 8'h77;
  localparam logic [7:0] ADDR_BATT     = 8'h78;
  localparam logic [7:0] ADDR_LEVEL    = 8'h79;
  localparam logic [7:0] ADDR_FLAGS    = 8'h8D;
  localparam logic [7:0] ADDR_STATE    = 8'h8E;
  localparam logic [7:0] ADDR_TXCNT    = 8'h8F;
  localparam logic [7:0] ADDR_RXCNT    = 8'h90;
  localparam logic [7:0] ADDR_CAL_HI   = 8'h94;
  localparam logic [7:0] ADDR_CAL_LO   = 8'h95;
  localparam logic [7:0] ADDR_VCO_AMP  = 8'h99;
  // Reset values
  localparam logic [7:0] RST_RATE_HI   = 8'h20;
  localparam logic [7:0] RST_RATE_LO   = 8'h00;
  localparam logic [7:0] RST_BATT      = 8'h39;
  localparam logic [7:0] RST_LEVEL     = 8'h42;
  localparam logic [7:0] RST_FLAGS     = 8'h52;
  localparam logic [3:0] RST_TRIM      = 4'h7;
  localparam logic [4:0] RST_FEEDBACK  = 5'h00;
  // Writable bits; reserved bits keep their reset value
  localparam logic [7:0] MASK_BATT     = 8'h7C;
  localparam logic [7:0] MASK_LEVEL    = 8'h71;
  // Field positions
  localparam int MULT_EN_BIT     = 7;
  localparam int BATT_EN_BIT     = 6;
  localparam int BATT_TH_LSB     = 4;
  localparam int LVL_MODE_BIT    = 3;
  localparam int BYPASS_BIT      = 2;
  localparam int LVL_SEL_LSB     = 4;
  localparam int SLEEP_SEL_BIT   = 0;
  localparam int CAL_OK_BIT      = 4;
  localparam int TX_FULL_BIT     = 2;
  localparam int RX_EMPTY_BIT    = 1;
  localparam int CAL_ERR_BIT     = 0;
  // Regulator level code for a fixed 1.4 V in receive
  localparam logic [2:0] LVL_CODE_1V4  = 3'h3;
  // Fixed divider terminal count (divide by four)
  localparam logic [1:0] DIV4_LAST     = 2'h3;
  // Rate multiplier accumulator width (ratio / 2^15)
  localparam int RATE_BITS       = 15;
  // Queue depth in entries
  localparam int QUEUE_DEPTH     = 128;
endpackage

// ==== pmcs_regs.sv ====
// Power management settings and controller status registers.
// Assumes a byte register port from the serial host front end and
// status words from the queues, controller and oscillator calibrator.
`timescale 1ns/1ns

// What this block does
// - Fifteen-bit divider ratio across two registers
// - Default settings give clock divided by four
// - Battery detector enable bit six
// - Two-bit battery threshold selects four levels
// - Level mode fixes receive level 1.4 V
// - Three-bit regulator level code field
// - Bit zero selects FIFO-retaining sleep
// - Calibration done flag reads one
// - Receive queue empty flag
// - Calibrator error flag reads one
// - Transmit queue entry count register
// - Receive queue entry count register
// - Trim word in high nibble
// - Five-bit feedback word split two registers
// - Multiplier gives ratio times clock over 2^15
// - Enable rising starts automatic calibration
module pmcs_regs #(
  parameter int QUEUE_DEPTH = pmcs_pkg::QUEUE_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Radio controller status
  input  wire logic [6:0] ctrl_state,
  input  wire logic       crystal_running,
  input  wire logic       antenna_choice,
  input  wire logic       radio_in_tx,
  input  wire logic [7:0] tx_queue_level,
  input  wire logic [7:0] rx_queue_level,
  input  wire logic [3:0] synth_cal_amplitude,
  // Oscillator calibrator
  input  wire logic       auto_osc_cal_enable,
  input  wire logic       cal_finish,
  input  wire logic       cal_fail,
  input  wire logic [3:0] cal_trim,
  input  wire logic [4:0] cal_feedback,
  output logic            cal_start,
  // Power management controls
  output logic            regulator_switch_tick,
  output logic            battery_detect_enable,
  output logic      [1:0] battery_detect_threshold,
  output logic      [2:0] regulator_level_applied,
  output logic            linear_regulator_bypass,
  output logic            sleep_fifo_retain
);

  logic [7:0]  rate_hi;
  logic [7:0]  rate_lo;
  logic [7:0]  batt_ctrl;
  logic [7:0]  level_ctrl;
  logic        osc_cal_done;
  logic        osc_cal_error;
  logic [3:0]  osc_trim_result;
  logic [4:0]  osc_feedback_result;
  logic        cal_en_q;
  logic [1:0]  div_cnt;
  logic [14:0] rate_acc;
  logic [15:0] next_rate_sum;
  logic [14:0] switch_divider_ratio;
  logic        switch_multiplier_enable;
  logic        tx_full;
  logic        rx_empty;
  logic        wr_hit;
  logic [7:0]  next_rdata;

  // Write strobe decode for one offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign switch_divider_ratio = {rate_hi[6:0], rate_lo};
  assign switch_multiplier_enable = rate_hi[pmcs_pkg::MULT_EN_BIT];
  assign next_rate_sum = {1'b0, rate_acc} + {1'b0, switch_divider_ratio};
  assign tx_full = (tx_queue_level == 8'(QUEUE_DEPTH));
  assign rx_empty = (rx_queue_level == 8'h00);
  assign wr_hit = reg_wr;

  // Writable configuration registers
  // read-only offsets never decode
  always_ff @(posedge clk) begin
    if (srst) begin
      rate_hi    <= pmcs_pkg::RST_RATE_HI;
      rate_lo    <= pmcs_pkg::RST_RATE_LO;
      batt_ctrl  <= pmcs_pkg::RST_BATT;
      level_ctrl <= pmcs_pkg::RST_LEVEL;
    end else if (wr_hit) begin
      if (hit(reg_addr, pmcs_pkg::ADDR_RATE_HI)) begin
        rate_hi <= reg_wdata;
      end
      if (hit(reg_addr, pmcs_pkg::ADDR_RATE_LO)) begin
        rate_lo <= reg_wdata;
      end
      if (hit(reg_addr, pmcs_pkg::ADDR_BATT)) begin
        batt_ctrl <= (reg_wdata & pmcs_pkg::MASK_BATT) | (pmcs_pkg::RST_BATT & ~pmcs_pkg::MASK_BATT);
      end
      if (hit(reg_addr, pmcs_pkg::ADDR_LEVEL)) begin
        level_ctrl <= (reg_wdata & pmcs_pkg::MASK_LEVEL) | (pmcs_pkg::RST_LEVEL & ~pmcs_pkg::MASK_LEVEL);
      end
    end
  end

  // Switching clock generation
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt               <= 2'h0;
      rate_acc              <= 15'h0000;
      regulator_switch_tick <= 1'b0;
    end else begin
      div_cnt  <= div_cnt + 2'h1;
      rate_acc <= next_rate_sum[14:0];
      if (switch_multiplier_enable) begin
        regulator_switch_tick <= next_rate_sum[15];
      end else begin
        regulator_switch_tick <= (div_cnt == pmcs_pkg::DIV4_LAST);
      end
    end
  end

  // Regulator and detector controls
  always_ff @(posedge clk) begin
    if (srst) begin
      battery_detect_enable    <= 1'b0;
      battery_detect_threshold <= 2'h0;
      regulator_level_applied  <= 3'h0;
      linear_regulator_bypass  <= 1'b0;
      sleep_fifo_retain        <= 1'b0;
    end else begin
      battery_detect_enable    <= batt_ctrl[pmcs_pkg::BATT_EN_BIT];
      battery_detect_threshold <= batt_ctrl[pmcs_pkg::BATT_TH_LSB +: 2];
      linear_regulator_bypass  <= batt_ctrl[pmcs_pkg::BYPASS_BIT];
      sleep_fifo_retain        <= level_ctrl[pmcs_pkg::SLEEP_SEL_BIT];
      if (batt_ctrl[pmcs_pkg::LVL_MODE_BIT] && !radio_in_tx) begin
        regulator_level_applied <= pmcs_pkg::LVL_CODE_1V4;
      end else begin
        regulator_level_applied <= level_ctrl[pmcs_pkg::LVL_SEL_LSB +: 3];
      end
    end
  end

  // Calibration start and result capture
  always_ff @(posedge clk) begin
    if (srst) begin
      cal_en_q            <= 1'b0;
      cal_start           <= 1'b0;
      osc_cal_done        <= pmcs_pkg::RST_FLAGS[pmcs_pkg::CAL_OK_BIT];
      osc_cal_error       <= pmcs_pkg::RST_FLAGS[pmcs_pkg::CAL_ERR_BIT];
      osc_trim_result     <= pmcs_pkg::RST_TRIM;
      osc_feedback_result <= pmcs_pkg::RST_FEEDBACK;
    end else begin
      cal_en_q  <= auto_osc_cal_enable;
      cal_start <= auto_osc_cal_enable && !cal_en_q;
      // done flag, set wins over clear
      if (cal_finish) begin
        osc_cal_done <= 1'b1;
      end else if (cal_start) begin
        osc_cal_done <= 1'b0;
      end
      // error flag, set wins over clear
      if (cal_fail) begin
        osc_cal_error <= 1'b1;
      end else if (cal_start) begin
        osc_cal_error <= 1'b0;
      end
      if (cal_finish) begin
        osc_trim_result     <= cal_trim;
        osc_feedback_result <= cal_feedback;
      end
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      pmcs_pkg::ADDR_RATE_HI: next_rdata = rate_hi;
      pmcs_pkg::ADDR_RATE_LO: next_rdata = rate_lo;
      pmcs_pkg::ADDR_BATT:    next_rdata = batt_ctrl;
      pmcs_pkg::ADDR_LEVEL:   next_rdata = level_ctrl;
      pmcs_pkg::ADDR_FLAGS:   next_rdata = {pmcs_pkg::RST_FLAGS[7:5], osc_cal_done, antenna_choice,
                                            tx_full, rx_empty, osc_cal_error};
      pmcs_pkg::ADDR_STATE:   next_rdata = {ctrl_state, crystal_running};
      pmcs_pkg::ADDR_TXCNT:   next_rdata = tx_queue_level;
      pmcs_pkg::ADDR_RXCNT:   next_rdata = rx_queue_level;
      pmcs_pkg::ADDR_CAL_HI:  next_rdata = {osc_trim_result, osc_feedback_result[4:1]};
      pmcs_pkg::ADDR_CAL_LO:  next_rdata = {osc_feedback_result[0], 7'h00};
      pmcs_pkg::ADDR_VCO_AMP: next_rdata = {4'h0, synth_cal_amplitude};
      default:                next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence div4_run;
    (regulator_switch_tick && !switch_multiplier_enable && !$past(switch_multiplier_enable))
      ##1 (!switch_multiplier_enable)[*3];
  endsequence

  sequence wr_to(logic [7:0] a);
    reg_wr && !reg_rd && reg_addr == a;
  endsequence

  // Calibration finish, then a flags read two cycles on with no restart between
  sequence done_then_flags;
    cal_finish ##1 (!cal_start)[*2] ##0 (reg_rd && reg_addr == pmcs_pkg::ADDR_FLAGS);
  endsequence

  // Calibration finish, then a result read five cycles on
  sequence done_then_trim;
    cal_finish ##1 (!cal_finish)[*5] ##0 (reg_rd && reg_addr == pmcs_pkg::ADDR_CAL_HI);
  endsequence

  // Calibration finish, then a low result read eight cycles on
  sequence done_then_lsb;
    cal_finish ##1 (!cal_finish)[*8] ##0 (reg_rd && reg_addr == pmcs_pkg::ADDR_CAL_LO);
  endsequence

  AST_DIV4_PERIOD: assert property (div4_run |=> regulator_switch_tick)
    else $error("switching tick not every fourth cycle");

  AST_DIV4_GAP: assert property (div4_run |-> $past(!regulator_switch_tick) && !regulator_switch_tick)
    else $error("extra switching tick in divide-by-four");

  AST_RATIO_HI: assert property (wr_to(pmcs_pkg::ADDR_RATE_HI)
    |=> switch_divider_ratio[14:8] == $past(reg_wdata[6:0]))
    else $error("ratio upper bits not loaded");

  AST_BATT_EN: assert property (wr_to(pmcs_pkg::ADDR_BATT)
    |=> ##1 battery_detect_enable == $past(reg_wdata[6], 2))
    else $error("detector enable does not follow bit six");

  AST_THRESHOLD: assert property (wr_to(pmcs_pkg::ADDR_BATT)
    |=> ##1 battery_detect_threshold == $past(reg_wdata[5:4], 2))
    else $error("detector threshold does not follow field");

  AST_RX_LEVEL: assert property (batt_ctrl[pmcs_pkg::LVL_MODE_BIT] && !radio_in_tx
    |=> regulator_level_applied == pmcs_pkg::LVL_CODE_1V4)
    else $error("receive level not fixed in level mode");

  AST_LEVEL_FIELD: assert property (!batt_ctrl[pmcs_pkg::LVL_MODE_BIT]
    |=> regulator_level_applied == $past(level_ctrl[6:4]))
    else $error("level code not taken from field");

  AST_SLEEP_SEL: assert property (wr_to(pmcs_pkg::ADDR_LEVEL)
    |=> ##1 sleep_fifo_retain == $past(reg_wdata[0], 2))
    else $error("sleep retention select does not follow bit zero");

  AST_CAL_DONE: assert property (done_then_flags |=> reg_rdata[pmcs_pkg::CAL_OK_BIT])
    else $error("calibration done flag not read as one");

  AST_TX_FULL: assert property (reg_rd && reg_addr == pmcs_pkg::ADDR_FLAGS
    |=> reg_rdata[pmcs_pkg::TX_FULL_BIT] == ($past(tx_queue_level) == 8'(QUEUE_DEPTH)))
    else $error("transmit full flag wrong");

  AST_RX_EMPTY: assert property (reg_rd && reg_addr == pmcs_pkg::ADDR_FLAGS
    |=> reg_rdata[pmcs_pkg::RX_EMPTY_BIT] == ($past(rx_queue_level) == 8'h00))
    else $error("receive empty flag wrong");

  AST_CAL_ERR: assert property (cal_fail |=> osc_cal_error)
    else $error("calibrator error not flagged");

  AST_TX_COUNT: assert property (reg_rd && reg_addr == pmcs_pkg::ADDR_TXCNT
    |=> reg_rdata == $past(tx_queue_level))
    else $error("transmit count misread");

  AST_RX_COUNT: assert property (reg_rd && reg_addr == pmcs_pkg::ADDR_RXCNT
    |=> reg_rdata == $past(rx_queue_level))
    else $error("receive count misread");

  AST_TRIM: assert property (done_then_trim |=> reg_rdata[7:4] == $past(cal_trim, 6))
    else $error("trim word not presented");

  AST_FEEDBACK_LSB: assert property (done_then_lsb |=> reg_rdata[7] == $past(cal_feedback[0], 9))
    else $error("feedback low bit misplaced");

  AST_CAL_START: assert property ($rose(auto_osc_cal_enable) |=> cal_start ##1 !cal_start)
    else $error("calibration start pulse missing");

  AST_RO_WRITE: assert property (wr_to(pmcs_pkg::ADDR_CAL_HI) ##0 !cal_finish
    |=> $stable(osc_trim_result) && $stable(osc_feedback_result))
    else $error("write changed read-only result");

endmodule

// ==== pmcs_host.sv ====
// Host model: byte strobe master on the register port.
// Assumes the bench calls its tasks only after reset release.
`timescale 1ns/1ns
module pmcs_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle bus shows the inverted address; wr also inverts the data, rd leaves the data as last driven
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= (a == pmcs_pkg::ADDR_BATT) ? (d & 8'hFB) : d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule

// ==== pmcs_regs_tb.sv ====
// Self-checking bench of the power and status register slice.
// Assumes pmcs_host as register master and a 25 MHz clock.
`timescale 1ns/1ns
module pmcs_regs_tb;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] addr, wdata, rdata, txl = 8'h00, rxl = 8'h00, d;
  logic       wr, rd, xo = 1'b0, ant = 1'b0, in_tx = 1'b0, cal_en = 1'b0, fin = 1'b0, fail = 1'b0;
  logic [6:0] cst = 7'h03;
  logic [3:0] amp = 4'h0, trim_in = 4'h0;
  logic [4:0] fb_in = 5'h00;
  logic       cal_start, tick, bde, byp, slp;
  logic [1:0] bdt;
  logic [2:0] lvl;
  int err_total = 0, n_checks = 0, cyc = 0, n, r, i, seed = 32'hea4d;
  int m76 = 32'h20, m77 = 0, m78 = 32'h39, m79 = 32'h42, done = 1, err = 0, trim = 7, fb = 0;
  logic [7:0] addrs [12] = '{8'h76, 8'h77, 8'h78, 8'h79, 8'h8D, 8'h8E, 8'h8F, 8'h90, 8'h94, 8'h95, 8'h99, 8'h55};

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  pmcs_host i_host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  pmcs_regs #(.QUEUE_DEPTH(128)) i_dut (.clk(clk), .srst(srst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .ctrl_state(cst), .crystal_running(xo),
    .antenna_choice(ant), .radio_in_tx(in_tx), .tx_queue_level(txl), .rx_queue_level(rxl),
    .synth_cal_amplitude(amp), .auto_osc_cal_enable(cal_en), .cal_finish(fin), .cal_fail(fail),
    .cal_trim(trim_in), .cal_feedback(fb_in), .cal_start(cal_start), .regulator_switch_tick(tick),
    .battery_detect_enable(bde), .battery_detect_threshold(bdt), .regulator_level_applied(lvl),
    .linear_regulator_bypass(byp), .sleep_fifo_retain(slp));

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h76: return m76[7:0];
      8'h77: return m77[7:0];
      8'h78: return m78[7:0];
      8'h79: return m79[7:0];
      8'h8D: return {3'b010, done[0], ant, txl == 8'd128, rxl == 8'd0, err[0]};
      8'h8E: return {cst, xo};
      8'h8F: return txl;
      8'h90: return rxl;
      8'h94: return {trim[3:0], fb[4:1]};
      8'h95: return {fb[0], 7'h00};
      8'h99: return {4'h0, amp};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a);
    i_host.rd(a, d);
    chk(d, exp_rd(a), $sformatf("read %h", a));
  endtask
  task automatic chk_outs();
    repeat (2) @(negedge clk);
    chk({bde, bdt, byp, slp, lvl}, {m78[6], m78[5:4], m78[2], m79[0], (m78[3] && !in_tx) ? 3'h3 : m79[6:4]}, "outputs");
  endtask
  task automatic chk_cnt(input int got, input int exp, input int tol, input string what);
    n_checks++;
    if (got > exp + tol || got < exp - tol) begin
      err_total++;
      $display("[FAIL] t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  // Counts switching ticks or calibration starts, one kind per call
  task automatic count(input int cycles, input bit sel_tick, output int c);
    c = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (sel_tick ? (tick === 1'b1) : (cal_start === 1'b1)) c++;
    end
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) fin <= 1'b1; else fail <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    fail <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    foreach (addrs[k]) chk_reg(addrs[k]);
    chk_outs();
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      i_host.wr(8'h78, {r[7:6], i[1:0], i[2], r[2:0]});
      m78 = ({r[7:6], i[1:0], i[2], r[2:0]} & 8'h78) | 8'h01;
      r = $random(seed);
      i_host.wr(8'h79, {r[7], i[2:0], r[3:0]});
      m79 = ({r[7], i[2:0], r[3:0]} & 8'h71) | 8'h02;
      in_tx <= r[8];
      chk_reg(8'h78);
      chk_reg(8'h79);
      chk_outs();
    end
    $display("test power settings done");
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      r = $random(seed);
      txl <= (i == 0) ? 8'd128 : 8'($unsigned(r) % 128);
      rxl <= (i == 1) ? 8'd0 : r[15:8];
      {cst, xo, ant, amp} <= r[28:16];
      foreach (addrs[k]) i_host.wr(addrs[k] | 8'h80, r[7:0]);
      i_host.wr(8'h55, r[7:0]);
      foreach (addrs[k]) chk_reg(addrs[k]);
    end
    $display("test status done");
    @(posedge clk);
    cal_en <= 1'b1;
    done = 0;
    count(6, 1'b0, n);
    chk_cnt(n, 1, 0, "start pulses");
    count(6, 1'b0, n);
    chk_cnt(n, 0, 0, "restart");
    chk_reg(8'h8D);
    @(posedge clk);
    {trim_in, fb_in} <= 9'($random(seed));
    pulse(0);
    trim = trim_in;
    fb = fb_in;
    done = 1;
    chk_reg(8'h8D);
    chk_reg(8'h94);
    chk_reg(8'h95);
    pulse(1);
    err = 1;
    chk_reg(8'h8D);
    @(posedge clk);
    cal_en <= 1'b0;
    $display("test calibrator done");
    count(400, 1'b1, n);
    chk_cnt(n, 100, 1, "divide by four");
    r = $random(seed);
    i_host.wr(8'h77, r[7:0]);
    i_host.wr(8'h76, {1'b1, r[14:8]});
    count(400, 1'b1, n);
    chk_cnt(n, (400 * r[14:0]) / 32768, 1, "rate multiplier");
    $display("test switching done");
    // Reset in mid-run brings back every setting and result word
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    m76 = 32'h20;
    m77 = 0;
    m78 = 32'h39;
    m79 = 32'h42;
    done = 1;
    err = 0;
    trim = 7;
    fb = 0;
    foreach (addrs[k]) chk_reg(addrs[k]);
    chk_outs();
    count(400, 1'b1, n);
    chk_cnt(n, 100, 1, "divide by four after reset");
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
